// file: core/asr_clkgen.sv
// bit and word clock generator for clock-master operation
`timescale 1ns/1ps
module asr_clkgen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic mtick,
  input wire logic [7:0] half_div,
  input wire logic [5:0] word_bits,
  input wire logic invert,
  // generated clocks
  output logic bclk_out,
  output logic lrclk_out
);
  typedef struct packed {
    logic [7:0] hc;
    logic [5:0] bc;
    logic ph;
    logic lr;
    logic bo;
    logic lo;
  } asr_cg_s;

  asr_cg_s q;
  asr_cg_s d;

  // half bit period counted in master clock ticks
  always_comb begin
    d = q;
    if (!run) begin
      d.hc = '0;
      d.bc = '0;
      d.ph = 1'b0;
      d.lr = 1'b0;
    end else if (mtick) begin
      if (q.hc == half_div) begin
        d.hc = '0;
        d.ph = ~q.ph;
        // word clock moves on a falling edge of the uninverted bit clock, away from sampling
        if (q.ph) begin
          if (q.bc == word_bits - 6'h01) begin
            d.bc = '0;
            d.lr = ~q.lr;
          end else begin
            d.bc = q.bc + 6'h01;
          end
        end
      end else begin
        d.hc = q.hc + 8'h01;
      end
    end
    d.bo = d.ph ^ invert;
    d.lo = d.lr;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bclk_out = q.bo;
  assign lrclk_out = q.lo;
endmodule

// file: core/asr_pkg.sv
// shared constants and types of the audio serial receiver
package asr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RXCFG = 8'h04;
  localparam logic [7:0] OFF_TXCFG = 8'h08;
  localparam logic [7:0] OFF_MCLK = 8'h0c;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_LEVEL = 8'h14;
  localparam logic [7:0] OFF_LIMIT = 8'h18;
  localparam logic [7:0] OFF_IEN_SET = 8'h1c;
  localparam logic [7:0] OFF_IEN_CLR = 8'h20;
  localparam logic [7:0] OFF_RAW = 8'h24;
  localparam logic [7:0] OFF_MIS = 8'h28;
  localparam logic [7:0] OFF_ICLR = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  // interrupt bit positions
  localparam int INT_RXERR = 0;
  localparam int INT_RXREQ = 1;
  localparam int INT_TXERR = 2;
  localparam int INT_TXREQ = 3;
  localparam int INT_N = 4;
  // control, clock-select and status fields
  localparam int CTRL_RXEN = 0;
  localparam int CTRL_TXEN = 1;
  localparam int MCLK_TXEXT = 0;
  localparam int MCLK_RXEXT = 1;
  localparam int MCLK_DIV = 8;
  localparam int STAT_EMPTY = 0;
  localparam int STAT_FULL = 1;
  // configuration word layout, same for both directions
  localparam int CFG_W = 12;
  localparam int CFG_FMT = 0;
  localparam int CFG_INV = 2;
  localparam int CFG_MODE = 3;
  localparam int CFG_MASTER = 5;
  localparam int CFG_SS = 6;
  localparam int CFG_WS = 9;
  // reset values and full word size
  localparam logic [4:0] LIMIT_RST = 5'h10;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [5:0] BITS_FULL = 6'h20;

  typedef enum logic [1:0] {
    fmt_standard = 2'h0,
    left_justified_framing = 2'h1,
    right_justified_framing = 2'h2
  } asr_fmt_e;

  typedef enum logic [1:0] {
    mode_dual = 2'h0,
    mode_compact16 = 2'h1,
    mode_compact8 = 2'h2,
    mode_mono = 2'h3
  } asr_mode_e;

  // size code to bit count; codes above the list fall back to 8
  function automatic logic [5:0] asr_size_bits(logic [2:0] code);
    case (code)
      3'h0: asr_size_bits = 6'h20;
      3'h1: asr_size_bits = 6'h18;
      3'h2: asr_size_bits = 6'h14;
      3'h3: asr_size_bits = 6'h10;
      default: asr_size_bits = 6'h08;
    endcase
  endfunction
endpackage

// file: core/asr_rx_top.sv
// audio serial receiver with interrupt unit and master clock selection
// How it works
// R1: four interrupt sources, each enabled individually onto the shared interrupt
// R2: any set of sources disabled at once; disabled ones never raise interrupt
// R3: pending sources stay set until software clears chosen ones
// R4: raw and masked interrupt status both readable
// R5: master clock per direction from internal divider or external pin
// R6: bit clock and word clock derived from selected master clock
// R7: transmit and receive configuration held separately
// R8: receiver frames in standard, left-justified or right-justified format
// R9: optional bit clock inversion moves sampling to the other edge
// R10: four channel modes: dual, compact 16, compact 8, mono
// R11: clock master drives serial clocks; as slave the partner drives them
// R12: sample size 32, 24, 20, 16 or 8 bits
// R13: wire word size 32, 24, 20, 16 or 8, independent of sample
// R14: dual mode reads alternate left then right
// R15: compact 16 read gives left low half, right high half
// R16: compact 8 read gives left bits 7-0, right next 8, rest zero
// R17: mono read returns one sample
// R18: receive FIFO empty flag readable for polling readers
// R19: software should clear pending sources early in its handler
// R20: service request while level exceeds limit; limit 16 disables it
// R21: level counts pairs and mono samples as two; odd means a dual-mode pair with its left sample already read
// R22: disabled receiver captures nothing from the serial pins
// R23: interrupt output is OR of the masked status bits
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module asr_rx_top #(
  parameter int FIFO_PAIRS = 8,
  parameter int MCLK_INT_DIV = 4
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // serial link
  input wire logic rx_bclk_in,
  output logic rx_bclk_out,
  output logic rx_bclk_oe,
  input wire logic rx_lrclk_in,
  output logic rx_lrclk_out,
  output logic rx_lrclk_oe,
  input wire logic rx_sdata_in,
  input wire logic mclk_ext_in,
  // transmit path
  input wire logic tx_error_event,
  input wire logic tx_service_event,
  output logic tx_master_clock_external,
  output logic tx_enable,
  output logic [11:0] tx_config,
  // interrupt
  output logic irq
);
  localparam int PW = $clog2(FIFO_PAIRS);
  localparam logic [7:0] MDIV_LAST = 8'(MCLK_INT_DIV - 1);

  if (FIFO_PAIRS != 2 ** PW || FIFO_PAIRS < 2 || FIFO_PAIRS > 8) begin : g_bad_depth
    $error("FIFO_PAIRS must be 2, 4 or 8");
  end
  if (MCLK_INT_DIV < 1 || MCLK_INT_DIV > 256) begin : g_bad_div
    $error("MCLK_INT_DIV must be 1 to 256");
  end

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rd_ok;
    logic rx_en;
    logic tx_en;
    logic [11:0] rxcfg;
    logic [11:0] txcfg;
    logic rx_master_clock_external;
    logic tx_master_clock_external;
    logic [7:0] bdiv;
    logic [4:0] limit;
    logic [3:0] ien;
    logic [3:0] raw;
    logic irq;
    logic oe;
    logic [1:0] bsync;
    logic [1:0] lsync;
    logic [1:0] dsync;
    logic [1:0] msync;
    logic bprev;
    logic lprev;
    logic mprev;
    logic [7:0] mdiv;
    logic started;
    logic chan;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [31:0] left;
    logic have_left;
    logic [FIFO_PAIRS-1:0][63:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] pairs;
    logic half;
  } asr_st_s;

  localparam asr_st_s ST_RST = '{limit: asr_pkg::LIMIT_RST, bdiv: asr_pkg::DIV_RST,
                                 default: '0};

  asr_st_s q;
  asr_st_s d;
  logic mtick;
  logic [4:0] lvl;
  asr_pkg::asr_fmt_e fmt;
  asr_pkg::asr_mode_e mode;
  logic [5:0] wbits;
  logic [5:0] sbits;

  assign fmt = asr_pkg::asr_fmt_e'(q.rxcfg[asr_pkg::CFG_FMT +: 2]); // R8
  assign mode = asr_pkg::asr_mode_e'(q.rxcfg[asr_pkg::CFG_MODE +: 2]); // R10
  assign wbits = asr_pkg::asr_size_bits(q.rxcfg[asr_pkg::CFG_WS +: 3]); // R13
  assign sbits = asr_pkg::asr_size_bits(q.rxcfg[asr_pkg::CFG_SS +: 3]); // R12
  assign lvl = 5'({q.pairs, 1'b0}) - 5'(q.half); // R21
  // receive master clock: external pin edge or internal divider tick
  assign mtick = q.rx_master_clock_external ? (q.msync[1] & ~q.mprev) // R5
                                            : (q.mdiv == MDIV_LAST);

  // master-mode clock generation; pins loop back through the input sync
  asr_clkgen u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .run(q.rx_en & q.rxcfg[asr_pkg::CFG_MASTER]),
    .mtick(mtick),
    .half_div(q.bdiv),
    .word_bits(wbits),
    .invert(q.rxcfg[asr_pkg::CFG_INV]),
    .bclk_out(rx_bclk_out),
    .lrclk_out(rx_lrclk_out)
  );

  // all next-state logic
  always_comb begin
    logic eff;
    logic edge_s;
    logic lr;
    logic bit_in;
    logic dlv;
    logic push;
    logic pop;
    logic setup;
    logic acc;
    logic wr;
    logic rj;
    logic [31:0] word;
    logic [31:0] smp;
    logic [31:0] rd;
    logic [63:0] top;
    logic [63:0] pair;
    logic [3:0] set;
    logic [3:0] clr;
    eff = 1'b0;
    edge_s = 1'b0;
    lr = 1'b0;
    bit_in = 1'b0;
    dlv = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    setup = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    rj = 1'b0;
    word = '0;
    smp = '0;
    rd = '0;
    top = '0;
    pair = '0;
    set = '0;
    clr = '0;
    d = q;
    // two-flop synchronisers for every serial link input
    d.bsync = {q.bsync[0], rx_bclk_in};
    d.lsync = {q.lsync[0], rx_lrclk_in};
    d.dsync = {q.dsync[0], rx_sdata_in};
    d.msync = {q.msync[0], mclk_ext_in};
    d.mprev = q.msync[1];
    d.mdiv = (q.mdiv == MDIV_LAST) ? '0 : q.mdiv + 8'h01;
    eff = q.bsync[1] ^ q.rxcfg[asr_pkg::CFG_INV]; // R9
    d.bprev = eff;
    edge_s = eff & ~q.bprev;
    lr = q.lsync[1];
    bit_in = q.dsync[1];
    rj = (fmt == asr_pkg::right_justified_framing);
    d.oe = q.rx_en & q.rxcfg[asr_pkg::CFG_MASTER]; // R11
    // frame parser; idle while disabled so no stale bits survive
    if (!q.rx_en) begin
      d.started = 1'b0; // R22
      d.cnt = '0;
      d.have_left = 1'b0;
      d.sh = '0;
      d.lprev = lr;
    end else if (edge_s) begin
      d.lprev = lr;
      if (lr != q.lprev) begin
        // right-justified word ends just before the word clock turns
        dlv = rj & q.started; // R8
        word = q.sh & (32'hffffffff >> (asr_pkg::BITS_FULL - wbits));
        // standard slot as long as the word: its lsb rides on the turn edge
        if (fmt == asr_pkg::fmt_standard && q.started && q.cnt == wbits - 6'h01) begin
          dlv = 1'b1; // R8
          word = {q.sh[30:0], bit_in};
        end
        d.started = 1'b1;
        d.chan = (fmt == asr_pkg::fmt_standard) ? ~lr : lr;
        // standard format has its msb one bit after the turn
        d.sh = (fmt == asr_pkg::fmt_standard) ? '0 : {31'h0, bit_in};
        d.cnt = (fmt == asr_pkg::fmt_standard) ? 6'h00 : 6'h01;
      end else if (rj) begin
        d.sh = {q.sh[30:0], bit_in};
      end else if (q.started && q.cnt < wbits) begin
        d.sh = {q.sh[30:0], bit_in};
        d.cnt = q.cnt + 6'h01;
        dlv = (d.cnt == wbits);
        word = d.sh;
      end
    end
    // wire word msb-aligned, then cut to sample size
    smp = (word << (asr_pkg::BITS_FULL - wbits)) >> (asr_pkg::BITS_FULL - sbits); // R12
    // pair assembly; mono keeps left words only, stored as a pair
    if (dlv) begin
      if (q.chan) begin
        d.left = smp;
        d.have_left = (mode != asr_pkg::mode_mono);
        push = (mode == asr_pkg::mode_mono); // R21
        pair = {32'h0, smp};
      end else if (q.have_left && mode != asr_pkg::mode_mono) begin
        push = 1'b1;
        d.have_left = 1'b0;
        pair = {smp, q.left};
      end
    end
    // apb: registered answer, no wait state
    setup = psel & ~penable;
    acc = psel & penable & q.pready;
    wr = acc & pwrite & ~q.pslverr;
    d.pready = setup;
    top = q.mem[q.rp];
    if (setup) begin
      d.pslverr = 1'b0;
      d.rd_ok = 1'b0;
      case (paddr)
        asr_pkg::OFF_CTRL: begin
          rd[asr_pkg::CTRL_RXEN] = q.rx_en;
          rd[asr_pkg::CTRL_TXEN] = q.tx_en;
        end
        asr_pkg::OFF_RXCFG: rd[asr_pkg::CFG_W-1:0] = q.rxcfg;
        asr_pkg::OFF_TXCFG: rd[asr_pkg::CFG_W-1:0] = q.txcfg;
        asr_pkg::OFF_MCLK: begin
          rd[asr_pkg::MCLK_TXEXT] = q.tx_master_clock_external;
          rd[asr_pkg::MCLK_RXEXT] = q.rx_master_clock_external;
          rd[asr_pkg::MCLK_DIV +: 8] = q.bdiv;
        end
        asr_pkg::OFF_RXDATA: begin
          d.rd_ok = ~pwrite & (q.pairs != '0);
          if (q.pairs != '0) begin
            unique case (mode)
              asr_pkg::mode_dual: rd = q.half ? top[63:32] : top[31:0]; // R14
              asr_pkg::mode_compact16: rd = {top[47:32], top[15:0]}; // R15
              asr_pkg::mode_compact8: rd = {16'h0, top[39:32], top[7:0]}; // R16
              asr_pkg::mode_mono: rd = top[31:0]; // R17
            endcase
          end
        end
        asr_pkg::OFF_LEVEL: rd[4:0] = lvl; // R21
        asr_pkg::OFF_LIMIT: rd[4:0] = q.limit;
        asr_pkg::OFF_IEN_SET: rd[asr_pkg::INT_N-1:0] = q.ien;
        asr_pkg::OFF_IEN_CLR: rd[asr_pkg::INT_N-1:0] = q.ien;
        asr_pkg::OFF_RAW: rd[asr_pkg::INT_N-1:0] = q.raw; // R4
        asr_pkg::OFF_MIS: rd[asr_pkg::INT_N-1:0] = q.raw & q.ien; // R4
        asr_pkg::OFF_ICLR: rd = '0;
        asr_pkg::OFF_STATUS: begin
          rd[asr_pkg::STAT_EMPTY] = (q.pairs == '0); // R18
          rd[asr_pkg::STAT_FULL] = (q.pairs == (PW + 1)'(FIFO_PAIRS));
        end
        default: d.pslverr = 1'b1;
      endcase
      d.prdata = rd;
    end
    // register writes take effect on the access edge
    if (wr) begin
      case (paddr)
        asr_pkg::OFF_CTRL: begin
          d.rx_en = pwdata[asr_pkg::CTRL_RXEN];
          d.tx_en = pwdata[asr_pkg::CTRL_TXEN];
        end
        asr_pkg::OFF_RXCFG: d.rxcfg = pwdata[asr_pkg::CFG_W-1:0]; // R7
        asr_pkg::OFF_TXCFG: d.txcfg = pwdata[asr_pkg::CFG_W-1:0]; // R7
        asr_pkg::OFF_MCLK: begin
          d.tx_master_clock_external = pwdata[asr_pkg::MCLK_TXEXT]; // R5
          d.rx_master_clock_external = pwdata[asr_pkg::MCLK_RXEXT]; // R5
          d.bdiv = pwdata[asr_pkg::MCLK_DIV +: 8]; // R6
        end
        asr_pkg::OFF_LIMIT: d.limit = pwdata[4:0];
        asr_pkg::OFF_IEN_SET: d.ien = q.ien | pwdata[asr_pkg::INT_N-1:0]; // R1
        asr_pkg::OFF_IEN_CLR: d.ien = q.ien & ~pwdata[asr_pkg::INT_N-1:0]; // R2
        asr_pkg::OFF_ICLR: clr = pwdata[asr_pkg::INT_N-1:0]; // R3
        default: d.ien = q.ien;
      endcase
    end
    // reads pop only what the setup cycle saw, so a late push is safe
    if (acc && !pwrite && paddr == asr_pkg::OFF_RXDATA && q.rd_ok) begin
      if (mode == asr_pkg::mode_dual && !q.half) begin
        d.half = 1'b1; // R14
      end else begin
        d.half = 1'b0;
        pop = 1'b1;
        d.rp = q.rp + PW'(1);
      end
    end
    // fifo push; a pair arriving when full with no pop in the same cycle is dropped and flagged
    if (push) begin
      if (q.pairs == (PW + 1)'(FIFO_PAIRS) && !pop) begin
        set[asr_pkg::INT_RXERR] = 1'b1;
        push = 1'b0;
      end else begin
        d.mem[q.wp] = pair;
        d.wp = q.wp + PW'(1);
      end
    end
    d.pairs = q.pairs + (PW + 1)'(push) - (PW + 1)'(pop);
    // sticky status; a new event beats a clear in the same cycle
    set[asr_pkg::INT_RXREQ] = (lvl > q.limit); // R20
    set[asr_pkg::INT_TXERR] = tx_error_event;
    set[asr_pkg::INT_TXREQ] = tx_service_event;
    d.raw = (q.raw & ~clr) | set; // R3
    d.irq = |(q.raw & q.ien); // R23
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign rx_bclk_oe = q.oe;
  assign rx_lrclk_oe = q.oe;
  assign tx_master_clock_external = q.tx_master_clock_external;
  assign tx_enable = q.tx_en;
  assign tx_config = q.txcfg;
  assign irq = q.irq;

  // fifo head halves, visible to the checks below
  logic [15:0] top16_r;
  logic [15:0] top16_l;
  assign top16_r = q.mem[q.rp][47:32];
  assign top16_l = q.mem[q.rp][15:0];

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  irq_or_a: assert property ((|(q.raw & q.ien)) |=> irq) // R23
    else $error("masked source pending but irq low");
  irq_gate_a: assert property (q.ien == '0 |=> !irq) // R2
    else $error("irq raised with all sources disabled");
  sticky_raw_a: assert property (q.raw[0] // R3
      && !(psel && penable && pwrite && q.pready && paddr == asr_pkg::OFF_ICLR) |=> q.raw[0])
    else $error("pending source dropped without clear");
  mis_read_a: assert property (rd_setup(asr_pkg::OFF_MIS) |=> prdata[3:0] == $past(q.raw & q.ien)) // R4
    else $error("masked status read wrong");
  svc_req_a: assert property (lvl > q.limit |=> q.raw[asr_pkg::INT_RXREQ]) // R20
    else $error("service request missing over limit");
  even_lvl_a: assert property (!q.half |-> !lvl[0]) // R21
    else $error("odd level without half read");
  no_capture_a: assert property (!q.rx_en ##1 !q.rx_en |-> q.pairs <= $past(q.pairs)) // R22
    else $error("data captured while disabled");
  dual_alt_a: assert property (rd_setup(asr_pkg::OFF_RXDATA) && mode == asr_pkg::mode_dual
      && !q.half && q.pairs != '0 ##1 penable && q.pready |=> q.half) // R14
    else $error("dual read did not move to right sample");
  cmp16_a: assert property (rd_setup(asr_pkg::OFF_RXDATA) && mode == asr_pkg::mode_compact16
      && q.pairs != '0 |=> prdata == {$past(top16_r), $past(top16_l)}) // R15
    else $error("compact 16 read layout wrong");
  master_oe_a: assert property (q.rx_en && q.rxcfg[asr_pkg::CFG_MASTER] |=> rx_bclk_oe) // R11
    else $error("master does not drive bit clock");
  empty_flag_a: assert property (rd_setup(asr_pkg::OFF_STATUS) ##1 penable |-> prdata[0] == ($past(q.pairs) == '0)) // R18
    else $error("empty flag wrong");

endmodule

// file: verif/asr_codec_model.sv
// far-side converter model driving slave-mode serial clocks and data
`timescale 1ns/1ps
module asr_codec_model (
  // serial link
  output logic bclk,
  output logic lrclk,
  output logic sdata
);
  // idle levels before the first frame
  initial begin
    bclk = 1'b0;
    lrclk = 1'b1;
    sdata = 1'b0;
  end

  // one left/right frame; clocks stand still outside it, data shows the inverse
  task automatic send_pair(input logic [31:0] l, input logic [31:0] r,
                           input logic [1:0] fmt, input logic inv, input int nb);
    logic rl;
    int k;
    int j;
    rl = (fmt == 2'h0);
    lrclk = rl;
    bclk = inv;
    // lead-in edge lets the receiver settle on the idle word clock level
    #43;
    bclk = !inv;
    #40;
    bclk = inv;
    for (k = 0; k < 2 * nb + 2; k++) begin
      j = k - int'(fmt == 2'h0);
      lrclk = (k < nb || k >= 2 * nb) ? !rl : rl;
      if (j >= 0 && j < 2 * nb) sdata = (j < nb) ? l[31 - j] : r[31 - (j - nb)];
      else sdata = !sdata;
      #40;
      bclk = !inv;
      #40;
      bclk = inv;
    end
    lrclk = rl;
    sdata = !sdata;
  endtask
endmodule

// file: verif/asr_rx_top_test.sv
// self-checking bench of the audio serial receiver
`timescale 1ns/1ps
module asr_rx_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mclk_ext = 1'b0;
  logic txe_ev = 1'b0;
  logic txs_ev = 1'b0;
  logic [2:0] mdiv = 3'h0;
  logic pready, pslverr, irq, bclk_o, bclk_oe, lr_o, lr_oe, m_bclk, m_lr, m_sd;
  logic tx_mext, tx_en;
  logic [31:0] prdata;
  logic [11:0] tx_cfg;
  localparam logic [31:0] left_val = 32'ha1b2c3d4;
  localparam logic [31:0] right_val = 32'h5e6f7081;
  int error_cnt = 0;
  int checks_done = 0;

  // bench clock, 8 ns period
  always #4 pclk = ~pclk;

  // external master clock, one rising edge every 6 pclk
  always @(posedge pclk) begin
    mdiv <= (mdiv == 3'h5) ? 3'h0 : mdiv + 3'h1;
    mclk_ext <= (mdiv < 3'h3);
  end

  asr_codec_model CODEC (
    .bclk(m_bclk),
    .lrclk(m_lr),
    .sdata(m_sd)
  );

  // clock pins resolve to whichever side drives them
  asr_rx_top DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rx_bclk_in(bclk_oe ? bclk_o : m_bclk),
    .rx_bclk_out(bclk_o),
    .rx_bclk_oe(bclk_oe),
    .rx_lrclk_in(lr_oe ? lr_o : m_lr),
    .rx_lrclk_out(lr_o),
    .rx_lrclk_oe(lr_oe),
    .rx_sdata_in(m_sd),
    .mclk_ext_in(mclk_ext),
    .tx_error_event(txe_ev),
    .tx_service_event(txs_ev),
    .tx_master_clock_external(tx_mext),
    .tx_enable(tx_en),
    .tx_config(tx_cfg),
    .irq(irq)
  );

  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; data taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer sampled at the rising edge itself, request released only after it
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, exp);
  endtask

  // one-cycle transmit event: 0 error, 1 service
  task automatic pulse(input logic which);
    @(posedge pclk);
    txe_ev <= !which;
    txs_ev <= which;
    @(posedge pclk);
    txe_ev <= 1'b0;
    txs_ev <= 1'b0;
  endtask

  // cycles until the driven bit clock, or word clock, changes level
  task automatic halfp(input logic wclk, output int c);
    logic v;
    c = 0;
    v = wclk ? lr_o : bclk_o;
    while ((wclk ? lr_o : bclk_o) === v && c < 1000) begin
      @(negedge pclk);
      c++;
    end
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rdchk("limit", asr_pkg::OFF_LIMIT, 32'h10);
    rdchk("status", asr_pkg::OFF_STATUS, 32'h1);
    apb(1'b1, 8'h80, 32'h1, q, e);
    check("unmapped", {31'h0, e}, 32'h1);
    wr(asr_pkg::OFF_TXCFG, 32'h6a5);
    wr(asr_pkg::OFF_RXCFG, 32'h123);
    wr(asr_pkg::OFF_MCLK, 32'h1);
    wr(asr_pkg::OFF_CTRL, 32'h2);
    rdchk("txcfg", asr_pkg::OFF_TXCFG, 32'h6a5);
    rdchk("rxcfg", asr_pkg::OFF_RXCFG, 32'h123);
    @(negedge pclk);
    check("tx config", {20'h0, tx_cfg}, 32'h6a5);
    check("tx mclk ext", {31'h0, tx_mext}, 32'h1);
    check("tx enable", {31'h0, tx_en}, 32'h1);
  endtask

  task automatic t_irq();
    pulse(1'b0);
    rdchk("raw", asr_pkg::OFF_RAW, 32'h4);
    rdchk("masked", asr_pkg::OFF_MIS, 32'h0);
    wr(asr_pkg::OFF_IEN_SET, 32'hf);
    pulse(1'b1);
    rdchk("enables", asr_pkg::OFF_IEN_SET, 32'hf);
    rdchk("masked", asr_pkg::OFF_MIS, 32'hc);
    repeat (2) @(negedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    wr(asr_pkg::OFF_IEN_CLR, 32'h4);
    rdchk("masked", asr_pkg::OFF_MIS, 32'h8);
    wr(asr_pkg::OFF_ICLR, 32'h8);
    rdchk("raw", asr_pkg::OFF_RAW, 32'h4);
    repeat (2) @(negedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    wr(asr_pkg::OFF_ICLR, 32'h4);
    rdchk("raw", asr_pkg::OFF_RAW, 32'h0);
    wr(asr_pkg::OFF_IEN_CLR, 32'hf);
  endtask

  // disabled receiver ignores a full frame; service request needs data
  task automatic t_idle();
    wr(asr_pkg::OFF_LIMIT, 32'h0);
    CODEC.send_pair(left_val, right_val, 2'h0, 1'b0, 32);
    rdchk("level", asr_pkg::OFF_LEVEL, 32'h0);
    rdchk("raw", asr_pkg::OFF_RAW, 32'h0);
  endtask

  // receive one frame, poll for data, drain and compare
  task automatic t_rx(input logic [1:0] fmt, input logic inv, input logic [1:0] mode,
                      input logic [2:0] ss, input logic [2:0] ws, input int nb,
                      input logic [31:0] e0, input logic [31:0] e1);
    int n;
    logic [31:0] q;
    logic e;
    wr(asr_pkg::OFF_RXCFG, {20'h0, ws, ss, 1'b0, mode, inv, fmt});
    wr(asr_pkg::OFF_CTRL, 32'h1);
    CODEC.send_pair(left_val, right_val, fmt, inv, nb);
    n = 0;
    do begin
      apb(1'b0, asr_pkg::OFF_STATUS, 32'h0, q, e);
      n++;
    end while (q[asr_pkg::STAT_EMPTY] !== 1'b0 && n < 20);
    check("data seen", 32'(n < 20), 32'h1);
    rdchk("level", asr_pkg::OFF_LEVEL, 32'h2);
    rdchk("rx word", asr_pkg::OFF_RXDATA, e0);
    if (mode == asr_pkg::mode_dual) begin
      rdchk("level odd", asr_pkg::OFF_LEVEL, 32'h1);
      rdchk("rx right", asr_pkg::OFF_RXDATA, e1);
    end
    rdchk("level", asr_pkg::OFF_LEVEL, 32'h0);
    wr(asr_pkg::OFF_CTRL, 32'h0);
  endtask

  // clock master: internal then external source, divisor applied
  task automatic t_master();
    int c;
    wr(asr_pkg::OFF_RXCFG, 32'h20);
    wr(asr_pkg::OFF_MCLK, 32'h0);
    wr(asr_pkg::OFF_CTRL, 32'h1);
    // output enable follows the enable bit one cycle later
    repeat (2) @(negedge pclk);
    check("clock oe", {30'h0, lr_oe, bclk_oe}, 32'h3);
    halfp(1'b0, c);
    halfp(1'b0, c);
    check("int half period", 32'(c), 32'h4);
    halfp(1'b1, c);
    halfp(1'b1, c);
    check("word half period", 32'(c), 32'h100);
    wr(asr_pkg::OFF_MCLK, 32'h102);
    halfp(1'b0, c);
    halfp(1'b0, c);
    halfp(1'b0, c);
    check("ext half period", 32'(c), 32'hc);
    wr(asr_pkg::OFF_CTRL, 32'h0);
    repeat (2) @(negedge pclk);
    check("clock oe", {30'h0, lr_oe, bclk_oe}, 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_irq();
    t_idle();
    t_rx(2'h0, 1'b0, 2'h0, 3'h1, 3'h0, 32, 32'h00a1b2c3, 32'h005e6f70);
    rdchk("raw", asr_pkg::OFF_RAW, 32'h2);
    wr(asr_pkg::OFF_ICLR, 32'h2);
    t_rx(2'h1, 1'b0, 2'h1, 3'h3, 3'h0, 32, 32'h5e6fa1b2, 32'h0);
    t_rx(2'h2, 1'b1, 2'h2, 3'h4, 3'h0, 32, 32'h00005ea1, 32'h0);
    t_rx(2'h0, 1'b0, 2'h3, 3'h2, 3'h1, 24, 32'h000a1b2c, 32'h0);
    t_master();
    test_done();
  end
endmodule
